// ==== core/cpl_dev_end.sv ====
// Driver end: self-clocked packet receiver, brightness latch and three PWM sinks.
//
// Implementation choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
// Function
// - Learn bit period from first two rises.
// - Rise before half period is one, else zero.
// - Packet-end hold freezes shift, forwards line downstream.
// - Eight-bit tick counter drives outputs versus level.
// - Controller latches only after all packets sent.
// - Latch hold loads levels, restarts PWM together.
// - Packet is command byte plus 24 data.
// - N devices need N packets per frame.
// - Any change resends packets for all devices.
// - Outputs stay off until levels are latched.
// - Packets go most significant bit first.
// - Copy only when command byte equals 3Ah.
// - Every packet is followed by packet end.
// - Same bit period for every packet.
// - 32-bit shift register, 24-bit latch, low copy.
// - Low bytes: channel 2, 1, 0 upward.
// - Top byte holds the write command.
module cpl_dev_end #(
   parameter int unsigned CNT_W              = cpl_pkg::CNT_W_DEF,
   parameter int unsigned EOS_HOLD_PERIODS   = cpl_pkg::EOS_HOLD_PERIODS_DEF,
   parameter int unsigned LATCH_HOLD_PERIODS = cpl_pkg::LATCH_HOLD_PERIODS_DEF,
   parameter int unsigned PWM_TICK_DIV       = cpl_pkg::PWM_TICK_DIV_DEF
) (
   input  wire logic                          clk_in,
   input  wire logic                          resetn_in,
   input  wire logic                          en_in,
   cpl_link_if.dev                            link,
   output logic [cpl_pkg::CHANNELS-1:0]       sink_output_out,
   output logic [cpl_pkg::DATA_W-1:0]         brightness_level_out,
   output logic                               forwarding_out,
   output logic                               latch_event_out
);
   localparam int unsigned HOLD_W = CNT_W + cpl_pkg::HOLD_EXTRA_W;
   localparam int unsigned DIV_W  = CNT_W;

   // ======================================================================
   // Receiver state
   cpl_pkg::cpl_dev_state_t             state_d;
   cpl_pkg::cpl_dev_state_t             state_q;
   logic                                line_prev_q;
   logic [CNT_W-1:0]                    bit_cnt_d;
   logic [CNT_W-1:0]                    bit_cnt_q;
   logic [CNT_W-1:0]                    bit_period_d;
   logic [CNT_W-1:0]                    bit_period_q;
   logic [HOLD_W-1:0]                   hold_cnt_d;
   logic [HOLD_W-1:0]                   hold_cnt_q;
   logic [cpl_pkg::PACKET_W-1:0]        serial_packet_shift_d;
   logic [cpl_pkg::PACKET_W-1:0]        serial_packet_shift_q;
   logic                                mid_seen_d;
   logic                                mid_seen_q;
   logic                                bit_done_d;
   logic                                bit_done_q;
   logic                                out_line_d;
   logic                                out_line_q;
   logic                                rise;
   logic [CNT_W-1:0]                    elapsed;
   logic [CNT_W-1:0]                    half_period;
   logic [HOLD_W-1:0]                   eos_limit;
   logic [HOLD_W-1:0]                   latch_limit;
   logic                                latch_fire;
   logic                                latch_valid;

   // ======================================================================
   // PWM state
   logic [cpl_pkg::DATA_W-1:0]          level_d;
   logic [cpl_pkg::DATA_W-1:0]          level_q;
   logic [cpl_pkg::LEVEL_W-1:0]         pwm_cnt_d;
   logic [cpl_pkg::LEVEL_W-1:0]         pwm_cnt_q;
   logic [DIV_W-1:0]                    tick_div_d;
   logic [DIV_W-1:0]                    tick_div_q;
   logic                                latch_evt_d;
   logic                                latch_evt_q;

   // Edge detection and the timing thresholds derived from the learned period.
   assign rise        = link.serial_line_in & ~line_prev_q;
   assign elapsed     = (bit_cnt_q == '1) ? bit_cnt_q : bit_cnt_q + 1'b1;
   assign half_period = bit_period_q >> cpl_pkg::HALF_SHIFT;
   assign eos_limit   = HOLD_W'(bit_period_q) * HOLD_W'(EOS_HOLD_PERIODS);
   assign latch_limit = HOLD_W'(bit_period_q) * HOLD_W'(LATCH_HOLD_PERIODS);

   // Latch fires once the line has been low for the latch hold after decoding began.
   assign latch_fire  = ((state_q == cpl_pkg::DEV_SHIFT) || (state_q == cpl_pkg::DEV_PASS)) &&
                        (hold_cnt_q >= latch_limit);
   assign latch_valid = latch_fire &&
                        (serial_packet_shift_q[cpl_pkg::PACKET_W-1:cpl_pkg::CMD_LSB] == cpl_pkg::CMD_WRITE);

   // Receiver next-state logic: measure, decode bits, freeze and forward.
   always_comb begin
      state_d               = state_q;
      bit_cnt_d             = elapsed;
      bit_period_d          = bit_period_q;
      serial_packet_shift_d = serial_packet_shift_q;
      mid_seen_d            = mid_seen_q;
      bit_done_d            = bit_done_q;
      hold_cnt_d            = rise ? '0 : ((hold_cnt_q == '1) ? hold_cnt_q : hold_cnt_q + 1'b1);
      out_line_d            = 1'b0;
      case (state_q)
         cpl_pkg::DEV_WAIT_FIRST: begin
            bit_cnt_d = '0;
            if (rise) begin
               state_d = cpl_pkg::DEV_MEASURE;
            end
         end
         cpl_pkg::DEV_MEASURE: begin
            if (rise) begin
               bit_cnt_d = '0;
               // The interval between the first two rises becomes the bit period.
               if ((elapsed >= CNT_W'(cpl_pkg::BIT_PERIOD_MIN_CYC)) &&
                   (elapsed <= CNT_W'(cpl_pkg::BIT_PERIOD_MAX_CYC))) begin
                  bit_period_d          = elapsed;
                  serial_packet_shift_d = {serial_packet_shift_q[cpl_pkg::PACKET_W-2:0], 1'b0};
                  mid_seen_d            = 1'b0;
                  bit_done_d            = 1'b0;
                  state_d               = cpl_pkg::DEV_SHIFT;
               end
            end else if (elapsed > CNT_W'(cpl_pkg::BIT_PERIOD_MAX_CYC)) begin
               state_d = cpl_pkg::DEV_WAIT_FIRST;
            end
         end
         cpl_pkg::DEV_SHIFT: begin
            if (rise && !bit_done_q && (elapsed < half_period)) begin
               mid_seen_d = 1'b1;
            end else if (rise) begin
               // A late rise opens the next bit; close the current one first if needed.
               if (!bit_done_q) begin
                  serial_packet_shift_d = {serial_packet_shift_q[cpl_pkg::PACKET_W-2:0], mid_seen_q};
               end
               bit_cnt_d  = '0;
               mid_seen_d = 1'b0;
               bit_done_d = 1'b0;
            end else if (!bit_done_q && (elapsed >= half_period)) begin
               serial_packet_shift_d = {serial_packet_shift_q[cpl_pkg::PACKET_W-2:0], mid_seen_q};
               bit_done_d            = 1'b1;
            end
            if (hold_cnt_q >= eos_limit) begin
               state_d = cpl_pkg::DEV_PASS;
            end
         end
         cpl_pkg::DEV_PASS: begin
            bit_cnt_d  = '0;
            out_line_d = link.serial_line_in;
         end
         default: begin
            state_d = cpl_pkg::DEV_WAIT_FIRST;
         end
      endcase
      if (latch_fire) begin
         state_d               = cpl_pkg::DEV_WAIT_FIRST;
         serial_packet_shift_d = '0;
         out_line_d            = 1'b0;
      end
   end

   // Receiver registers.
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         state_q               <= cpl_pkg::DEV_WAIT_FIRST;
         line_prev_q           <= 1'b0;
         bit_cnt_q             <= '0;
         bit_period_q          <= CNT_W'(cpl_pkg::BIT_PERIOD_MAX_CYC);
         hold_cnt_q            <= '0;
         serial_packet_shift_q <= '0;
         mid_seen_q            <= 1'b0;
         bit_done_q            <= 1'b0;
         out_line_q            <= 1'b0;
      end else if (en_in) begin
         state_q               <= state_d;
         line_prev_q           <= link.serial_line_in;
         bit_cnt_q             <= bit_cnt_d;
         bit_period_q          <= bit_period_d;
         hold_cnt_q            <= hold_cnt_d;
         serial_packet_shift_q <= serial_packet_shift_d;
         mid_seen_q            <= mid_seen_d;
         bit_done_q            <= bit_done_d;
         out_line_q            <= out_line_d;
      end
   end

   // ======================================================================
   // Brightness latch and PWM counter
   // A valid latch copies the low 24 bits, clears the counter and restarts the tick.
   always_comb begin
      level_d     = level_q;
      pwm_cnt_d   = pwm_cnt_q;
      tick_div_d  = tick_div_q;
      latch_evt_d = latch_valid;
      if (latch_valid) begin
         level_d    = serial_packet_shift_q[cpl_pkg::DATA_W-1:0];
         pwm_cnt_d  = '0;
         tick_div_d = '0;
      end else if (tick_div_q == DIV_W'(PWM_TICK_DIV - 1)) begin
         tick_div_d = '0;
         pwm_cnt_d  = pwm_cnt_q + 1'b1;
      end else begin
         tick_div_d = tick_div_q + 1'b1;
      end
   end

   // PWM registers; levels reset to zero so every sink stays off.
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         level_q     <= '0;
         pwm_cnt_q   <= '0;
         tick_div_q  <= '0;
         latch_evt_q <= 1'b0;
      end else if (en_in) begin
         level_q     <= level_d;
         pwm_cnt_q   <= pwm_cnt_d;
         tick_div_q  <= tick_div_d;
         latch_evt_q <= latch_evt_d;
      end
   end

   // One comparator per channel; channel i takes its byte from the mapped lane.
   genvar ch;
   generate
      for (ch = 0; ch < cpl_pkg::CHANNELS; ch++) begin : g_chan
         cpl_pwm_channel u_chan (
            .clk_in          (clk_in),
            .resetn_in       (resetn_in),
            .en_in           (en_in),
            .level_in        (level_q[cpl_pkg::CH_LSB[ch] +: cpl_pkg::LEVEL_W]),
            .count_in        (pwm_cnt_q),
            .sink_output_out (sink_output_out[ch])
         );
      end
   endgenerate

   // Outputs; forwarding_out is decoded from state_q, the others are registers.
   assign link.serial_line_out = out_line_q;
   assign brightness_level_out = level_q;
   assign forwarding_out       = (state_q == cpl_pkg::DEV_PASS);
   assign latch_event_out      = latch_evt_q;
endmodule

// ==== core/cpl_pkg.sv ====
// Shared constants and types for the cascaded PWM packet latch link.
package cpl_pkg;
   // ======================================================================
   // Clock and bit timing
   localparam int unsigned CLK_PERIOD_NS         = 50;
   localparam int unsigned BIT_PERIOD_MIN_NS     = 1660;
   localparam int unsigned BIT_PERIOD_MAX_NS     = 50000;
   localparam int unsigned BIT_PERIOD_MIN_CYC    = (BIT_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned BIT_PERIOD_MAX_CYC    = BIT_PERIOD_MAX_NS / CLK_PERIOD_NS;
   localparam int unsigned CNT_W_DEF             = 16;
   localparam int unsigned HOLD_EXTRA_W          = 4;
   localparam int unsigned EOS_HOLD_PERIODS_DEF  = 4;
   localparam int unsigned LATCH_HOLD_PERIODS_DEF = 8;
   localparam int unsigned PWM_TICK_DIV_DEF      = 4;
   localparam int unsigned HALF_SHIFT            = 1;
   localparam int unsigned MID_SHIFT             = 2;
   localparam int unsigned PULSE_SHIFT           = 3;

   // ======================================================================
   // Packet layout
   localparam int unsigned PACKET_W  = 32;
   localparam int unsigned DATA_W    = 24;
   localparam int unsigned LEVEL_W   = 8;
   localparam int unsigned CHANNELS  = 3;
   localparam int unsigned CMD_LSB   = 24;
   localparam int unsigned CH_LSB [0:2] = '{16, 8, 0};
   localparam logic [7:0]  CMD_WRITE = 8'h3a;

   // ======================================================================
   // Controller registers on AHB-Lite
   localparam int unsigned ADDR_W         = 8;
   localparam logic [7:0]  REG_CTRL       = 8'h00;
   localparam logic [7:0]  REG_STATUS     = 8'h04;
   localparam logic [7:0]  REG_PACKET     = 8'h08;
   localparam logic [7:0]  REG_PERIOD     = 8'h0c;
   localparam logic [7:0]  REG_CHAIN      = 8'h10;
   localparam int unsigned CTRL_LATCH_BIT = 0;
   localparam int unsigned STAT_BUSY_BIT  = 0;
   localparam int unsigned STAT_DONE_BIT  = 1;
   localparam int unsigned STAT_SENT_LSB  = 8;
   localparam int unsigned SENT_W         = 8;
   localparam logic [15:0] PERIOD_RESET   = 16'h0028;
   localparam logic [7:0]  CHAIN_RESET    = 8'h01;
   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
   localparam logic        HRESP_OKAY     = 1'h0;

   // ======================================================================
   // State encodings
   typedef enum logic [1:0] {DEV_WAIT_FIRST, DEV_MEASURE, DEV_SHIFT, DEV_PASS} cpl_dev_state_t;
   typedef enum logic [1:0] {HOST_IDLE, HOST_BITS, HOST_HOLD} cpl_host_state_t;
endpackage

// ==== core/cpl_link_if.sv ====
// Single-wire link between the controller and the first driver of the chain.
`timescale 1ns/1ns
interface cpl_link_if;
   logic serial_line_in;
   logic serial_line_out;

   // The controller drives the line; the driver forwards it downstream.
   modport host (output serial_line_in);
   modport dev  (input serial_line_in, output serial_line_out);
endinterface

// ==== core/cpl_pwm_channel.sv ====
// One PWM sink channel comparing the shared counter with its latched level.
`timescale 1ns/1ns
module cpl_pwm_channel (
   input  wire logic                         clk_in,
   input  wire logic                         resetn_in,
   input  wire logic                         en_in,
   input  wire logic [cpl_pkg::LEVEL_W-1:0]  level_in,
   input  wire logic [cpl_pkg::LEVEL_W-1:0]  count_in,
   output logic                              sink_output_out
);
   logic on_d;
   logic on_q;

   // The sink is on from count one while the count does not exceed the level.
   always_comb begin
      on_d = (count_in != '0) && (count_in <= level_in);
   end

   // Outputs start off after reset.
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         on_q <= 1'b0;
      end else if (en_in) begin
         on_q <= on_d;
      end
   end

   assign sink_output_out = on_q;
endmodule

// ==== core/cpl_host_end.sv ====
// Controller end: AHB-Lite registers and the single-wire packet transmitter.
`timescale 1ns/1ns
module cpl_host_end #(
   parameter int unsigned CNT_W              = cpl_pkg::CNT_W_DEF,
   parameter int unsigned EOS_HOLD_PERIODS   = cpl_pkg::EOS_HOLD_PERIODS_DEF,
   parameter int unsigned LATCH_HOLD_PERIODS = cpl_pkg::LATCH_HOLD_PERIODS_DEF
) (
   input  wire logic         clk_in,
   input  wire logic         resetn_in,
   input  wire logic         en_in,
   input  wire logic         hsel_in,
   input  wire logic [31:0]  haddr_in,
   input  wire logic [1:0]   htrans_in,
   input  wire logic         hwrite_in,
   input  wire logic [2:0]   hsize_in,
   input  wire logic [31:0]  hwdata_in,
   input  wire logic         hready_in,
   output logic              hreadyout_out,
   output logic [31:0]       hrdata_out,
   output logic              hresp_out,
   cpl_link_if.host          link
);
   localparam int unsigned HOLD_W = CNT_W + cpl_pkg::HOLD_EXTRA_W;

   // ======================================================================
   // Bus and transmitter state
   cpl_pkg::cpl_host_state_t         state_d;
   cpl_pkg::cpl_host_state_t         state_q;
   logic                             dp_wr_d;
   logic                             dp_wr_q;
   logic [cpl_pkg::ADDR_W-1:0]       dp_addr_d;
   logic [cpl_pkg::ADDR_W-1:0]       dp_addr_q;
   logic [31:0]                      rdata_d;
   logic [31:0]                      rdata_q;
   logic [CNT_W-1:0]                 period_d;
   logic [CNT_W-1:0]                 period_q;
   logic [cpl_pkg::SENT_W-1:0]       chain_d;
   logic [cpl_pkg::SENT_W-1:0]       chain_q;
   logic [cpl_pkg::SENT_W-1:0]       sent_d;
   logic [cpl_pkg::SENT_W-1:0]       sent_q;
   logic [cpl_pkg::PACKET_W-1:0]     word_d;
   logic [cpl_pkg::PACKET_W-1:0]     word_q;
   logic [4:0]                       bit_idx_d;
   logic [4:0]                       bit_idx_q;
   logic [HOLD_W-1:0]                cyc_d;
   logic [HOLD_W-1:0]                cyc_q;
   logic [HOLD_W-1:0]                hold_len_d;
   logic [HOLD_W-1:0]                hold_len_q;
   logic                             latching_d;
   logic                             latching_q;
   logic                             line_d;
   logic                             line_q;
   logic                             busy;
   logic                             stall;
   logic                             wr_done;
   logic [HOLD_W-1:0]                pw;
   logic [HOLD_W-1:0]                mid;
   logic [31:0]                      status;

   assign busy   = (state_q != cpl_pkg::HOST_IDLE);
   // Packet and latch orders wait in the data phase until the line is idle.
   assign stall  = dp_wr_q && busy && ((dp_addr_q == cpl_pkg::REG_PACKET) || (dp_addr_q == cpl_pkg::REG_CTRL));
   assign wr_done = dp_wr_q && !stall;
   assign pw     = HOLD_W'(period_q) >> cpl_pkg::PULSE_SHIFT;
   assign mid    = HOLD_W'(period_q) >> cpl_pkg::MID_SHIFT;
   assign status = {16'h0000, sent_q, 6'h00, (sent_q == chain_q), busy};

   // Register access and transmitter sequencing.
   always_comb begin
      state_d    = state_q;
      dp_wr_d    = dp_wr_q && stall;
      dp_addr_d  = dp_addr_q;
      rdata_d    = rdata_q;
      period_d   = period_q;
      chain_d    = chain_q;
      sent_d     = sent_q;
      word_d     = word_q;
      bit_idx_d  = bit_idx_q;
      cyc_d      = cyc_q + 1'b1;
      hold_len_d = hold_len_q;
      latching_d = latching_q;
      if (hsel_in && hready_in && (htrans_in == cpl_pkg::HTRANS_NONSEQ)) begin
         dp_wr_d   = hwrite_in;
         dp_addr_d = haddr_in[cpl_pkg::ADDR_W-1:0];
         case (haddr_in[cpl_pkg::ADDR_W-1:0])
            cpl_pkg::REG_STATUS: rdata_d = status;
            cpl_pkg::REG_PERIOD: rdata_d = 32'(period_q);
            cpl_pkg::REG_CHAIN:  rdata_d = 32'(chain_q);
            default:             rdata_d = 32'h00000000;
         endcase
      end
      case (state_q)
         cpl_pkg::HOST_IDLE: begin
            cyc_d = '0;
         end
         cpl_pkg::HOST_BITS: begin
            if (cyc_q == HOLD_W'(period_q) - 1'b1) begin
               cyc_d = '0;
               if (bit_idx_q == '0) begin
                  state_d = cpl_pkg::HOST_HOLD;
               end else begin
                  bit_idx_d = bit_idx_q - 1'b1;
               end
            end
         end
         cpl_pkg::HOST_HOLD: begin
            if (cyc_d >= hold_len_q) begin
               state_d = cpl_pkg::HOST_IDLE;
               if (latching_q) begin
                  sent_d     = '0;
                  latching_d = 1'b0;
               end
            end
         end
         default: begin
            state_d = cpl_pkg::HOST_IDLE;
         end
      endcase
      if (wr_done) begin
         case (dp_addr_q)
            cpl_pkg::REG_PACKET: begin
               word_d     = hwdata_in;
               bit_idx_d  = 5'(cpl_pkg::PACKET_W - 1);
               cyc_d      = '0;
               hold_len_d = HOLD_W'(period_q) * HOLD_W'(EOS_HOLD_PERIODS);
               sent_d     = sent_q + 1'b1;
               state_d    = cpl_pkg::HOST_BITS;
            end
            cpl_pkg::REG_CTRL: begin
               if (hwdata_in[cpl_pkg::CTRL_LATCH_BIT] && (sent_q == chain_q) && (sent_q != '0)) begin
                  cyc_d      = '0;
                  hold_len_d = HOLD_W'(period_q) * HOLD_W'(LATCH_HOLD_PERIODS);
                  latching_d = 1'b1;
                  state_d    = cpl_pkg::HOST_HOLD;
               end
            end
            cpl_pkg::REG_PERIOD: begin
               if (sent_q == '0) begin
                  period_d = hwdata_in[CNT_W-1:0];
               end
            end
            cpl_pkg::REG_CHAIN: begin
               chain_d = hwdata_in[cpl_pkg::SENT_W-1:0];
            end
            default: begin
               chain_d = chain_q;
            end
         endcase
      end
      // Each bit opens with a pulse; a one adds a second pulse at a quarter period.
      line_d = (state_d == cpl_pkg::HOST_BITS) &&
               ((cyc_d < pw) || (word_d[bit_idx_d] && (cyc_d >= mid) && (cyc_d < mid + pw)));
   end

   // Bus and transmitter registers.
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         state_q    <= cpl_pkg::HOST_IDLE;
         dp_wr_q    <= 1'b0;
         dp_addr_q  <= '0;
         rdata_q    <= '0;
         period_q   <= CNT_W'(cpl_pkg::PERIOD_RESET);
         chain_q    <= cpl_pkg::CHAIN_RESET;
         sent_q     <= '0;
         word_q     <= '0;
         bit_idx_q  <= '0;
         cyc_q      <= '0;
         hold_len_q <= '0;
         latching_q <= 1'b0;
         line_q     <= 1'b0;
      end else if (en_in) begin
         state_q    <= state_d;
         dp_wr_q    <= dp_wr_d;
         dp_addr_q  <= dp_addr_d;
         rdata_q    <= rdata_d;
         period_q   <= period_d;
         chain_q    <= chain_d;
         sent_q     <= sent_d;
         word_q     <= word_d;
         bit_idx_q  <= bit_idx_d;
         cyc_q      <= cyc_d;
         hold_len_q <= hold_len_d;
         latching_q <= latching_d;
         line_q     <= line_d;
      end
   end

   assign hreadyout_out       = !stall;
   assign hrdata_out          = rdata_q;
   assign hresp_out           = cpl_pkg::HRESP_OKAY;
   assign link.serial_line_in = line_q;
endmodule

// ==== dv/cpl_link_asserts.sv ====
// Checker for the first driver and the link that feeds it.
`timescale 1ns/1ns
module cpl_link_asserts (
   input wire logic        clk_in,
   input wire logic        resetn_in,
   input wire logic        serial_line_in,
   input wire logic        serial_line_out,
   input wire logic [2:0]  sink_output_out,
   input wire logic [23:0] brightness_level_out,
   input wire logic        forwarding_out,
   input wire logic        latch_event_out
);
   // ======================
   // Low-time counter
   logic [15:0] low_q;
   logic [15:0] low_d;
   // Counts cycles since the line was last high, saturating.
   always_comb low_d = serial_line_in ? 16'h0 : (&low_q ? low_q : low_q + 16'h1);
   // Registers the count.
   always_ff @(posedge clk_in) low_q <= resetn_in ? low_d : 16'h0;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   a_fwd_copy: assert property (forwarding_out && $past(forwarding_out)
      |-> serial_line_out == $past(serial_line_in)) else $error("bad copy");
   a_out_quiet: assert property (!forwarding_out && !$past(forwarding_out)
      |-> !serial_line_out) else $error("line out not idle");
   a_fwd_hold: assert property ($rose(forwarding_out) |-> low_q >= 16'd120)
      else $error("early forward");
   a_latch_hold: assert property ($changed(brightness_level_out) |-> low_q >= 16'd250)
      else $error("early latch");
   a_level_event: assert property ($changed(brightness_level_out) |-> ##[0:1] latch_event_out)
      else $error("level change without event");
   a_event_pulse: assert property (latch_event_out |=> !latch_event_out)
      else $error("long event");
   a_sink_level: assert property ((sink_output_out & ~{|$past(brightness_level_out[7:0]),
      |$past(brightness_level_out[15:8]), |$past(brightness_level_out[23:16])}) == 3'h0)
      else $error("sink on at zero");
   a_latch_dark: assert property (latch_event_out |=> (sink_output_out == 3'h0)[*2])
      else $error("no restart");
endmodule

// ==== dv/cascaded_pwm_packet_latch_test.sv ====
// Bench: controller and two cascaded drivers.
`timescale 1ns/1ns
module cascaded_pwm_packet_latch_test;
   logic        clk_in = 1'b0;
   logic        resetn_in = 1'b0;
   logic        hsel_in = 1'b0;
   logic        hwrite_in = 1'b0;
   logic [1:0]  htrans_in = 2'h0;
   logic [31:0] haddr_in = 32'h0;
   logic [31:0] hwdata_in = 32'h0;
   logic [31:0] hrdata_out, r;
   logic        hreadyout_out, hresp_out, forwarding_out, latch_event_out;
   logic [2:0]  sink_output_out, sink2;
   logic [23:0] brightness_level_out, lvl2;
   int          n_mismatch = 0;
   int          n_checks = 0;
   int          on [4];
   cpl_link_if link ();
   cpl_link_if link2 ();
   // Clock and the cascade wire.
   always #25 clk_in = ~clk_in;
   assign link2.serial_line_in = link.serial_line_out;
   cpl_host_end cpl_host_end_inst (.clk_in, .resetn_in, .en_in(1'b1), .hsel_in, .haddr_in, .htrans_in,
      .hwrite_in, .hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out), .hreadyout_out, .hrdata_out,
      .hresp_out, .link(link.host));
   cpl_dev_end cpl_dev_end_inst (.clk_in, .resetn_in, .en_in(1'b1), .link(link.dev), .sink_output_out,
      .brightness_level_out, .forwarding_out, .latch_event_out);
   cpl_dev_end cpl_dev_end_inst_b (.clk_in, .resetn_in, .en_in(1'b1), .link(link2.dev),
      .sink_output_out(sink2), .brightness_level_out(lvl2), .forwarding_out(), .latch_event_out());
   cpl_link_asserts cpl_link_asserts_inst (.clk_in, .resetn_in, .serial_line_in(link.serial_line_in),
      .serial_line_out(link.serial_line_out), .sink_output_out, .brightness_level_out, .forwarding_out,
      .latch_event_out);
   // ======================
   // Tasks
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Waits, bounded, for hready at a rising edge.
   task automatic wt();
      int n;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (hreadyout_out !== 1'b1 && n < 9000);
      if (n >= 9000) begin
         n_mismatch++;
         wrap_up();
      end
   endtask
   // One single-word bus transfer; read data lands in r.
   task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel_in <= 1'b1;
      htrans_in <= 2'h2;
      haddr_in <= {24'h0, a};
      hwrite_in <= w;
      wt();
      hsel_in <= 1'b0;
      htrans_in <= 2'h0;
      hwdata_in <= d;
      wt();
      r = hrdata_out;
   endtask
   // Sends two packets, orders the latch and polls until idle.
   task automatic frame(input logic [31:0] p0, input logic [31:0] p1);
      xf(1'b1, 8'h08, p0);
      xf(1'b1, 8'h08, p1);
      xf(1'b1, 8'h00, 32'h1);
      // The latch write reads back zero, so force at least one status poll.
      r = 32'h1;
      for (int i = 0; i < 900 && r[0] !== 1'b0; i++) xf(1'b0, 8'h04, 32'h0);
      chk(r, 32'h0);
   endtask
   // ======================
   // Main sequence
   initial begin
      repeat (16) @(posedge clk_in);
      resetn_in <= 1'b1;
      xf(1'b0, 8'h0c, 32'h0);
      chk(r, 32'h28);
      xf(1'b0, 8'h20, 32'h0);
      chk(r, 32'h0);
      chk({8'h0, brightness_level_out}, 32'h0);
      chk({29'h0, sink_output_out}, 32'h0);
      xf(1'b1, 8'h10, 32'h2);
      frame(32'h3aa50100, 32'h3a0000ff);
      chk({31'h0, hresp_out}, 32'h0);
      chk({8'h0, brightness_level_out}, 32'ha50100);
      chk({8'h0, lvl2}, 32'hff);
      repeat (1024) begin
         @(posedge clk_in);
         for (int i = 0; i < 3; i++) on[i] += sink_output_out[i];
         on[3] += sink2[2];
      end
      chk(on[0], 660);
      chk(on[1], 4);
      chk(on[2], 0);
      chk(on[3], 1020);
      frame(32'h3b123456, 32'h3a00ff00);
      chk({8'h0, brightness_level_out}, 32'ha50100);
      chk({8'h0, lvl2}, 32'hff00);
      wrap_up();
   end
endmodule
